// *** rtl/ssc_regs.sv ***
`timescale 1ns/10ps
`include "ssc_defs.svh"

// Notes on behaviour
// - non-revertive: keep current source; change only when it fails
// - revertive: always take highest-priority valid source, reverting automatically
// - rate bit picks 2048 kHz (clear) or 1544 kHz (set); reset value from pin
// - second loop feedback: analog when bit 6 clear, digital when set
// - input 2 receiver: LVDS when bit 1 clear, PECL when set
// - sync enable clear: first loop ignores the external frame sync
module ssc_regs
   import ssc_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [9:0]              paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    rate_family_strap,
   input  wire logic [`SSC_NUM_SRC-1:0] src_valid,
   input  wire logic                    ext_frame_sync,
   output logic                         input_rate_family_sel,
   output logic      [11:0]             low_rate_khz,
   output logic                         revertive_en,
   output logic      [1:0]              selected_src,
   output logic                         first_loop_sync,
   output logic                         pll2_digital_loop_sel,
   output logic                         clk_in1_level_sel,
   output logic                         clk_in2_level_sel
);

   // ***************************************************************
   // decoding
   // ***************************************************************

   // register number of a bus address, or zero when unaligned
   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      if (addr[1:0] != 2'h0)
      begin
         idx = 8'h00;
      end
      return idx;
   endfunction

   // true when the address selects an implemented register
   function automatic logic is_mapped(input logic [9:0] addr);
      logic [7:0] idx;
      idx = reg_index(addr);
      return (idx == `SSC_IDX_SRC_SEL) || (idx == `SSC_IDX_PLL2_PATH) ||
             (idx == `SSC_IDX_DIFF_IN);
   endfunction

   // implemented bit positions of a register; shared by the read and
   // write paths so both agree on which positions exist
   function automatic logic [7:0] reg_mask(input logic [7:0] idx);
      logic [7:0] mask;
      case (idx)
         `SSC_IDX_SRC_SEL:   mask = `SSC_MASK_SRC_SEL;
         `SSC_IDX_PLL2_PATH: mask = `SSC_MASK_PLL2_PATH;
         `SSC_IDX_DIFF_IN:   mask = `SSC_MASK_DIFF_IN;
         default:            mask = 8'h00;
      endcase
      return mask;
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************

   ssc_state_type s_q;
   ssc_state_type s_d;
   logic [1:0]    pick_src;
   logic [7:0]    rd_byte;
   logic [7:0]    wr_byte;
   logic          wr_take;

   // ***************************************************************
   // source picker
   // ***************************************************************

   // source picker fed by the registered control bits; its answer is
   // registered below, so a change of source shows one cycle later
   ssc_src_pick u_pick
   (
      .src_valid (src_valid),
      .cur_src   (s_q.cur_src),
      .revertive (s_q.src_sel[`SSC_BIT_REVERT]),
      .next_src  (pick_src)
   );

   // ***************************************************************
   // read path
   // ***************************************************************

   // read view of the addressed register; unused positions and
   // unmapped addresses read as zero
   always_comb
   begin
      case (reg_index(paddr))
         `SSC_IDX_SRC_SEL:   rd_byte = s_q.src_sel;
         `SSC_IDX_PLL2_PATH: rd_byte = s_q.pll2_path;
         `SSC_IDX_DIFF_IN:   rd_byte = s_q.diff_in;
         default:            rd_byte = 8'h00;
      endcase
      rd_byte = rd_byte & reg_mask(reg_index(paddr));
   end

   // ***************************************************************
   // next state
   // ***************************************************************

   // next state: bus answer, register writes, strap and status
   always_comb
   begin
      s_d     = s_q;
      wr_byte = pwdata[7:0] & reg_mask(reg_index(paddr));
      wr_take = psel && penable && s_q.pready && pwrite && pstrb[0] &&
                is_mapped(paddr);

      // bus answer: ready one cycle after setup, data and error with it
      // no wait states, so pready is simply the registered setup phase
      s_d.pready  = psel && !penable;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (psel && !penable)
      begin
         s_d.pslverr = !is_mapped(paddr);
         if (!pwrite)
         begin
            s_d.prdata = {24'h00_0000, rd_byte};
         end
      end

      // register writes, masked to the implemented positions
      if (wr_take)
      begin
         case (reg_index(paddr))
            `SSC_IDX_SRC_SEL:   s_d.src_sel = wr_byte & `SSC_MASK_SRC_SEL;
            `SSC_IDX_PLL2_PATH: s_d.pll2_path = wr_byte & `SSC_MASK_PLL2_PATH;
            `SSC_IDX_DIFF_IN:   s_d.diff_in = wr_byte & `SSC_MASK_DIFF_IN;
            default:            s_d.src_sel = s_q.src_sel;
         endcase
      end

      // rate family strap caught once, on the first edge after reset release
      // a bus write landing on that same edge loses bit 2 to the strap
      if (!s_q.strap_done)
      begin
         s_d.strap_done              = 1'b1;
         s_d.src_sel[`SSC_BIT_RATE]  = rate_family_strap;
      end

      // low-rate input setting follows the rate family bit
      if (s_q.src_sel[`SSC_BIT_RATE])
      begin
         s_d.low_rate = `SSC_RATE_SONET_KHZ;
      end
      else
      begin
         s_d.low_rate = `SSC_RATE_SDH_KHZ;
      end

      // reference selection under the revert mode
      s_d.cur_src  = pick_src;

      // frame sync passes to the first loop only when enabled
      s_d.sync_out = ext_frame_sync && s_q.src_sel[`SSC_BIT_SYNC_EN];
   end

   // ***************************************************************
   // state register
   // ***************************************************************

   // registers; reset loads the defaults masked to the implemented
   // positions, and the strap is taken only after release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q            <= '0;
         s_q.src_sel    <= `SSC_RST_SRC_SEL & `SSC_MASK_SRC_SEL;
         s_q.pll2_path  <= `SSC_RST_PLL2_PATH & `SSC_MASK_PLL2_PATH;
         s_q.diff_in    <= `SSC_RST_DIFF_IN & `SSC_MASK_DIFF_IN;
         s_q.cur_src    <= `SSC_SRC_NONE;
         s_q.low_rate   <= `SSC_RATE_SDH_KHZ;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************

   // every output is a field of the state register
   // nothing combinational reaches a pin
   assign prdata                = s_q.prdata;
   assign pready                = s_q.pready;
   assign pslverr               = s_q.pslverr;
   assign input_rate_family_sel = s_q.src_sel[`SSC_BIT_RATE];
   assign low_rate_khz          = s_q.low_rate;
   assign revertive_en          = s_q.src_sel[`SSC_BIT_REVERT];
   assign selected_src          = s_q.cur_src;
   assign first_loop_sync       = s_q.sync_out;
   assign pll2_digital_loop_sel = s_q.pll2_path[`SSC_BIT_PLL2_DIG];
   assign clk_in1_level_sel     = s_q.diff_in[`SSC_BIT_IN1_PECL];
   assign clk_in2_level_sel     = s_q.diff_in[`SSC_BIT_IN2_PECL];

endmodule

// *** rtl/ssc_defs.svh ***
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// register indices; the byte address is four times the index
`define SSC_IDX_SRC_SEL     8'h34
`define SSC_IDX_PLL2_PATH   8'h35
`define SSC_IDX_DIFF_IN     8'h36

// field positions
`define SSC_BIT_REVERT      0
`define SSC_BIT_RATE        2
`define SSC_BIT_SYNC_EN     3
`define SSC_BIT_PLL2_DIG    6
`define SSC_BIT_IN1_PECL    0
`define SSC_BIT_IN2_PECL    1

// reset values, before masking of unused positions
`define SSC_RST_SRC_SEL     8'h00
`define SSC_RST_PLL2_PATH   8'ha0
`define SSC_RST_DIFF_IN     8'h03

// implemented bit positions of each register
`define SSC_MASK_SRC_SEL    8'h0d
`define SSC_MASK_PLL2_PATH  8'h40
`define SSC_MASK_DIFF_IN    8'h03

// generic low-rate input setting, in kHz
`define SSC_RATE_SDH_KHZ    12'h800
`define SSC_RATE_SONET_KHZ  12'h608

// source selection
`define SSC_NUM_SRC         3
`define SSC_SRC_NONE        2'h3

`endif

// *** rtl/ssc_pkg.sv ***
`include "ssc_defs.svh"

package ssc_pkg;

   // complete state of the register bank
   typedef struct packed
   {
      logic [7:0]  src_sel;
      logic [7:0]  pll2_path;
      logic [7:0]  diff_in;
      logic        strap_done;
      logic [1:0]  cur_src;
      logic        sync_out;
      logic [11:0] low_rate;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ssc_state_type;

endpackage

// *** rtl/ssc_src_pick.sv ***
`timescale 1ns/10ps
`include "ssc_defs.svh"

// ***************************************************************
// source picker
// ***************************************************************
module ssc_src_pick
   import ssc_pkg::*;
(
   input  wire logic [`SSC_NUM_SRC-1:0] src_valid,
   input  wire logic [1:0]              cur_src,
   input  wire logic                    revertive,
   output logic      [1:0]              next_src
);

   logic [1:0] best;
   logic       cur_ok;

   // lowest index is highest priority; scan from lowest priority up
   always_comb
   begin
      best = `SSC_SRC_NONE;
      for (int i = `SSC_NUM_SRC - 1; i >= 0; i--)
      begin
         if (src_valid[i])
         begin
            best = 2'(i);
         end
      end
      cur_ok = (cur_src != `SSC_SRC_NONE) && src_valid[cur_src];
      if (revertive)
      begin
         next_src = best;
      end
      else if (cur_ok)
      begin
         next_src = cur_src;
      end
      else
      begin
         next_src = best;
      end
   end

endmodule

// *** bench/ssc_regs_assertions.sv ***
`timescale 1ns/10ps
`include "ssc_defs.svh"

// *****
// checker
// *****
module ssc_chk
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    input_rate_family_sel,
   input wire logic [11:0]             low_rate_khz,
   input wire logic                    revertive_en,
   input wire logic [`SSC_NUM_SRC-1:0] src_valid,
   input wire logic [1:0]              selected_src,
   input wire logic                    ext_frame_sync,
   input wire logic                    first_loop_sync,
   input wire logic                    pll2_digital_loop_sel,
   input wire logic                    clk_in1_level_sel,
   input wire logic                    clk_in2_level_sel
);
   logic wr;
   // completed write
   assign wr = psel && penable && pwrite && pready;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY: assert property (psel && !penable |=> pready)
      else $error("ready missing");
   AST_ERR: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   AST_HI: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_RATE: assert property (low_rate_khz ==
      ($past(input_rate_family_sel) ? `SSC_RATE_SONET_KHZ : `SSC_RATE_SDH_KHZ))
      else $error("low rate wrong");
   AST_REV: assert property (revertive_en && src_valid[0] |=> selected_src == 2'h0)
      else $error("no revert to first source");
   AST_KEEP: assert property (!revertive_en && selected_src != 2'h3 &&
      src_valid[selected_src] |=> $stable(selected_src))
      else $error("valid source dropped");
   AST_NONE: assert property (src_valid == 3'h0 |=> selected_src == 2'h3)
      else $error("source chosen with none valid");
   AST_SYNC: assert property (first_loop_sync |-> $past(ext_frame_sync))
      else $error("sync without input");
   AST_PLL2: assert property ($changed(pll2_digital_loop_sel) |->
      $past(wr) || $past(wr, 2))
      else $error("feedback mode moved alone");
   AST_LVL: assert property ($changed({clk_in1_level_sel, clk_in2_level_sel}) |->
      $past(wr) || $past(wr, 2))
      else $error("level select moved alone");
   cover property (wr);
   cover property (pslverr);
   cover property (revertive_en && selected_src == 2'h0);
endmodule

bind ssc_regs ssc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .input_rate_family_sel(input_rate_family_sel), .low_rate_khz(low_rate_khz),
   .revertive_en(revertive_en), .src_valid(src_valid), .selected_src(selected_src),
   .ext_frame_sync(ext_frame_sync), .first_loop_sync(first_loop_sync),
   .pll2_digital_loop_sel(pll2_digital_loop_sel), .clk_in1_level_sel(clk_in1_level_sel),
   .clk_in2_level_sel(clk_in2_level_sel));

// *** bench/tb_top.sv ***
`timescale 1ns/10ps

// *****
// bench
// *****
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, strap, efs, e;
   logic        pready, pslverr, rate, rev, sync, dig, in1, in2;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb;
   logic [2:0]  src;
   logic [1:0]  sel;
   logic [11:0] low;
   int          bad_count, check_count, i;

   always #10 pclk = ~pclk;

   ssc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rate_family_strap(strap), .src_valid(src),
      .ext_frame_sync(efs), .input_rate_family_sel(rate), .low_rate_khz(low),
      .revertive_en(rev), .selected_src(sel), .first_loop_sync(sync),
      .pll2_digital_loop_sel(dig), .clk_in1_level_sel(in1), .clk_in2_level_sel(in2));

   task complete_run;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask

   // one transfer; holds everything until ready is sampled high at an edge
   task apb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         bad_count++;
         complete_run;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [9:0] a, input logic [7:0] ex, input logic er);
      apb(1'b0, a, 8'h0, 4'h0);
      chk("prdata", {24'h0, ex}, r);
      chk("pslverr", {31'h0, er}, {31'h0, e});
   endtask

   task settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, efs, src, paddr, pwdata, pstrb} = '0;
      {strap, bad_count, check_count} = {1'b1, 64'h0};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      chk("rate", 1, rate);
      chk("low", 12'h608, low);
      rd(10'h0d0, 8'h04, 1'b0);
      rd(10'h0d4, 8'h00, 1'b0);
      rd(10'h0d8, 8'h03, 1'b0);
      rd(10'h0dc, 8'h00, 1'b1);
      rd(10'h0d1, 8'h00, 1'b1);
      apb(1'b1, 10'h0d4, 8'hff, 4'h1);
      rd(10'h0d4, 8'h40, 1'b0);
      apb(1'b1, 10'h0d4, 8'h00, 4'h0);
      rd(10'h0d4, 8'h40, 1'b0);
      settle;
      chk("dig", 1, dig);
      apb(1'b1, 10'h0d4, 8'hbf, 4'h1);
      settle;
      chk("dig", 0, dig);
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, 10'h0d8, i[7:0], 4'h1);
         settle;
         chk("level", i[1:0], {in2, in1});
      end
      apb(1'b1, 10'h0d0, 8'hff, 4'h1);
      rd(10'h0d0, 8'h0d, 1'b0);
      chk("rev", 1, rev);
      @(posedge pclk) src <= 3'b110;
      settle;
      chk("src", 1, sel);
      @(posedge pclk) src <= 3'b111;
      settle;
      chk("src", 0, sel);
      @(posedge pclk) efs <= 1'b1;
      settle;
      chk("sync", 1, sync);
      apb(1'b1, 10'h0d0, 8'h00, 4'h1);
      settle;
      chk("rev", 0, rev);
      chk("sync", 0, sync);
      chk("low", 12'h800, low);
      @(posedge pclk) src <= 3'b110;
      settle;
      @(posedge pclk) src <= 3'b111;
      settle;
      chk("src", 1, sel);
      @(posedge pclk) src <= 3'b101;
      settle;
      chk("src", 0, sel);
      // second reset with the strap low: the pin value must be taken again
      @(posedge pclk) {presetn, strap} <= 2'b00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle;
      chk("rate", 0, rate);
      chk("low", 12'h800, low);
      rd(10'h0d0, 8'h00, 1'b0);
      rd(10'h0d4, 8'h00, 1'b0);
      complete_run;
   end
endmodule
